/* File: include/acrb_pkg.sv */
// package of the configuration register bank: map, fields, defaults, serial framing
// assumes one clock domain; all users refer to names as acrb_pkg::name
package acrb_pkg;

   // ==========================================================
   // serial word framing
   localparam int unsigned WORD_BITS = 16;
   localparam int unsigned ADDR_BITS = 8;
   localparam int unsigned DATA_BITS = 8;
   localparam logic [3:0] LAST_ADDR_BIT = 4'h7;
   localparam logic [3:0] LAST_WORD_BIT = 4'hF;

   // ==========================================================
   // register offsets
   localparam logic [7:0] INIT_AND_READBACK_CTL = 8'h00;
   localparam logic [7:0] DISTORTION_TUNING_CTL = 8'h02;
   localparam logic [7:0] OUTPUT_FORMAT_CTL = 8'h3C;
   localparam logic [7:0] REFERENCE_AND_POWER_CTL = 8'h44;
   localparam logic [7:0] GAIN_CTL = 8'h45;

   // ==========================================================
   // field positions
   localparam int unsigned READBACK_BIT = 0;
   localparam int unsigned SOFT_INIT_BIT = 1;
   localparam logic [7:0] DISTORTION_TUNING_MASK = 8'h71;
   localparam int unsigned FORMAT_SOURCE_BIT = 7;
   localparam int unsigned FORMAT_SELECT_BIT = 6;
   localparam int unsigned REF_SOURCE_BIT = 3;
   localparam int unsigned REF_SELECT_BIT = 2;
   localparam int unsigned POWER_DOWN_BIT = 6;
   localparam int unsigned GAIN_MSB = 7;
   localparam int unsigned GAIN_LSB = 4;
   localparam int unsigned GAIN_BYPASS_BIT = 3;

   // ==========================================================
   // reset values
   localparam logic RESET_READBACK = 1'b0;
   localparam logic [7:0] RESET_DISTORTION = 8'h00;
   localparam logic RESET_FORMAT_SOURCE = 1'b0;
   localparam logic RESET_FORMAT_SELECT = 1'b0;
   localparam logic RESET_REF_SOURCE = 1'b0;
   localparam logic RESET_REF_SELECT = 1'b0;
   localparam logic RESET_POWER_DOWN = 1'b0;
   localparam logic [3:0] RESET_GAIN = 4'h0;
   localparam logic RESET_GAIN_BYPASS = 1'b0;

   // ==========================================================
   // serial receiver phases
   typedef enum logic [2:0] {
      ACRB_IDLE = 3'b001,
      ACRB_ADDR = 3'b010,
      ACRB_DATA = 3'b100
   } acrb_phase_t;

endpackage

/* File: verilog/acrb_bank.sv */
// configuration register bank of a pipelined converter behind a three-wire serial port
// assumes serial pins already synchronous to clk_i (serial clock far below clk_i)
//
// Operation
// - init bit restores every register default while readback is off
// - bit 0 of address 0 enables readback
// - format source bit picks strap or register
// - format bit used only under override
// - reference source bit picks strap or register
// - reference bit used only under override
// - four-bit fine gain, default zero
// - bypass bit skips fine gain stage
// - 16-bit words, address then data, falling edges
// - readback blocks all writes but the readback bit, drives addressed data
// - init bit clears itself afterwards
`timescale 1ns/1ps
`default_nettype none

module acrb_bank (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // serial port
   input wire logic serial_clk_i,
   input wire logic serial_select_n_i,
   input wire logic serial_data_in_i,
   output logic readback_data_out_o,
   // strap pin shared by format and reference
   input wire logic format_ref_strap_pin_i,
   // controls toward the converter
   output logic readback_en_o,
   output logic [7:0] distortion_tuning_bits_o,
   output logic offset_binary_o,
   output logic ext_reference_o,
   output logic power_down_bit_o,
   output logic [3:0] fine_gain_o,
   output logic gain_bypass_o
);

   // ==========================================================
   // state
   acrb_pkg::acrb_phase_t phase_r, phase_nxt;
   logic sclk_r, sclk_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [14:0] shift_r, shift_nxt;
   logic [7:0] rd_shift_r, rd_shift_nxt;
   logic rd_out_r, rd_out_nxt;
   logic rb_r, rb_nxt;
   logic [7:0] dist_r, dist_nxt;
   logic fmt_src_r, fmt_src_nxt;
   logic fmt_sel_r, fmt_sel_nxt;
   logic ref_src_r, ref_src_nxt;
   logic ref_sel_r, ref_sel_nxt;
   logic pdn_r, pdn_nxt;
   logic [3:0] gain_r, gain_nxt;
   logic byp_r, byp_nxt;
   logic fmt_eff_r, fmt_eff_nxt;
   logic ref_eff_r, ref_eff_nxt;
   logic sclk_fall, sclk_rise, wr_stb, soft_init;
   logic [7:0] wr_addr, wr_data;

   // register read decode, reserved bits as zero
   function automatic logic [7:0] reg_read(input logic [7:0] addr);
      logic [7:0] v;
      v = 8'h00;
      unique case (addr)
         acrb_pkg::INIT_AND_READBACK_CTL: v[acrb_pkg::READBACK_BIT] = rb_r;
         acrb_pkg::DISTORTION_TUNING_CTL: v = dist_r;
         acrb_pkg::OUTPUT_FORMAT_CTL: begin
            v[acrb_pkg::FORMAT_SOURCE_BIT] = fmt_src_r;
            v[acrb_pkg::FORMAT_SELECT_BIT] = fmt_sel_r;
         end
         acrb_pkg::REFERENCE_AND_POWER_CTL: begin
            v[acrb_pkg::REF_SOURCE_BIT] = ref_src_r;
            v[acrb_pkg::REF_SELECT_BIT] = ref_sel_r;
            v[acrb_pkg::POWER_DOWN_BIT] = pdn_r;
         end
         acrb_pkg::GAIN_CTL: begin
            v[acrb_pkg::GAIN_MSB:acrb_pkg::GAIN_LSB] = gain_r;
            v[acrb_pkg::GAIN_BYPASS_BIT] = byp_r;
         end
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // ==========================================================
   // serial receiver
   // edges of the serial clock against the previous sample
   assign sclk_fall = sclk_r & ~serial_clk_i;
   assign sclk_rise = ~sclk_r & serial_clk_i;
   // a word completes on its 16th falling edge
   assign wr_stb = sclk_fall & ~serial_select_n_i & (phase_r == acrb_pkg::ACRB_DATA) &
                   (cnt_r == acrb_pkg::LAST_WORD_BIT);
   assign wr_addr = shift_r[14:7];
   assign wr_data = {shift_r[6:0], serial_data_in_i};
   assign soft_init = wr_stb & ~rb_r & (wr_addr == acrb_pkg::INIT_AND_READBACK_CTL) &
                      wr_data[acrb_pkg::SOFT_INIT_BIT];

   // shift, count and readback drive
   always_comb begin
      sclk_nxt = serial_clk_i;
      phase_nxt = phase_r;
      cnt_nxt = cnt_r;
      shift_nxt = shift_r;
      rd_shift_nxt = rd_shift_r;
      rd_out_nxt = rd_out_r;
      if (serial_select_n_i) begin
         // partial words are dropped when select rises
         phase_nxt = acrb_pkg::ACRB_IDLE;
         cnt_nxt = 4'h0;
         rd_out_nxt = 1'b0;
      end else begin
         if (phase_r == acrb_pkg::ACRB_IDLE) begin
            phase_nxt = acrb_pkg::ACRB_ADDR;
         end
         if (sclk_fall) begin
            shift_nxt = {shift_r[13:0], serial_data_in_i};
            cnt_nxt = cnt_r + 4'h1;
            if (cnt_r == acrb_pkg::LAST_ADDR_BIT) begin
               phase_nxt = acrb_pkg::ACRB_DATA;
               rd_shift_nxt = reg_read({shift_r[6:0], serial_data_in_i});
            end else if (cnt_r == acrb_pkg::LAST_WORD_BIT) begin
               phase_nxt = acrb_pkg::ACRB_ADDR;
            end else if (phase_r == acrb_pkg::ACRB_IDLE) begin
               phase_nxt = acrb_pkg::ACRB_ADDR;
            end
         end
         // data bits move out on rising edges, controller takes them on falling
         if (sclk_rise) begin
            if (rb_r && phase_r == acrb_pkg::ACRB_DATA) begin
               rd_out_nxt = rd_shift_r[7];
               rd_shift_nxt = {rd_shift_r[6:0], 1'b0};
            end else begin
               rd_out_nxt = 1'b0;
            end
         end
         // a stale data bit must not linger once readback is switched off
         if (!rb_r) begin
            rd_out_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase_r <= acrb_pkg::ACRB_IDLE;
         sclk_r <= 1'b1; // serial clock parks high, so no false edge after reset
         cnt_r <= 4'h0;
         shift_r <= 15'h0000;
         rd_shift_r <= 8'h00;
         rd_out_r <= 1'b0;
      end else begin
         phase_r <= phase_nxt;
         sclk_r <= sclk_nxt;
         cnt_r <= cnt_nxt;
         shift_r <= shift_nxt;
         rd_shift_r <= rd_shift_nxt;
         rd_out_r <= rd_out_nxt;
      end
   end

   // ==========================================================
   // register file
   // write decode; readback mode lets only the readback bit through
   always_comb begin
      rb_nxt = rb_r;
      dist_nxt = dist_r;
      fmt_src_nxt = fmt_src_r;
      fmt_sel_nxt = fmt_sel_r;
      ref_src_nxt = ref_src_r;
      ref_sel_nxt = ref_sel_r;
      pdn_nxt = pdn_r;
      gain_nxt = gain_r;
      byp_nxt = byp_r;
      if (soft_init) begin
         // same defaults as the reset input; the init bit is never stored
         rb_nxt = acrb_pkg::RESET_READBACK;
         dist_nxt = acrb_pkg::RESET_DISTORTION;
         fmt_src_nxt = acrb_pkg::RESET_FORMAT_SOURCE;
         fmt_sel_nxt = acrb_pkg::RESET_FORMAT_SELECT;
         ref_src_nxt = acrb_pkg::RESET_REF_SOURCE;
         ref_sel_nxt = acrb_pkg::RESET_REF_SELECT;
         pdn_nxt = acrb_pkg::RESET_POWER_DOWN;
         gain_nxt = acrb_pkg::RESET_GAIN;
         byp_nxt = acrb_pkg::RESET_GAIN_BYPASS;
      end else if (wr_stb) begin
         if (wr_addr == acrb_pkg::INIT_AND_READBACK_CTL) begin
            rb_nxt = wr_data[acrb_pkg::READBACK_BIT];
         end else if (!rb_r) begin
            unique case (wr_addr)
               acrb_pkg::DISTORTION_TUNING_CTL: begin
                  dist_nxt = wr_data & acrb_pkg::DISTORTION_TUNING_MASK;
               end
               acrb_pkg::OUTPUT_FORMAT_CTL: begin
                  fmt_src_nxt = wr_data[acrb_pkg::FORMAT_SOURCE_BIT];
                  fmt_sel_nxt = wr_data[acrb_pkg::FORMAT_SELECT_BIT];
               end
               acrb_pkg::REFERENCE_AND_POWER_CTL: begin
                  ref_src_nxt = wr_data[acrb_pkg::REF_SOURCE_BIT];
                  ref_sel_nxt = wr_data[acrb_pkg::REF_SELECT_BIT];
                  pdn_nxt = wr_data[acrb_pkg::POWER_DOWN_BIT];
               end
               acrb_pkg::GAIN_CTL: begin
                  gain_nxt = wr_data[acrb_pkg::GAIN_MSB:acrb_pkg::GAIN_LSB];
                  byp_nxt = wr_data[acrb_pkg::GAIN_BYPASS_BIT];
               end
               default: begin
                  // unmapped addresses are ignored
                  dist_nxt = dist_r;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rb_r <= acrb_pkg::RESET_READBACK;
         dist_r <= acrb_pkg::RESET_DISTORTION;
         fmt_src_r <= acrb_pkg::RESET_FORMAT_SOURCE;
         fmt_sel_r <= acrb_pkg::RESET_FORMAT_SELECT;
         ref_src_r <= acrb_pkg::RESET_REF_SOURCE;
         ref_sel_r <= acrb_pkg::RESET_REF_SELECT;
         pdn_r <= acrb_pkg::RESET_POWER_DOWN;
         gain_r <= acrb_pkg::RESET_GAIN;
         byp_r <= acrb_pkg::RESET_GAIN_BYPASS;
      end else begin
         rb_r <= rb_nxt;
         dist_r <= dist_nxt;
         fmt_src_r <= fmt_src_nxt;
         fmt_sel_r <= fmt_sel_nxt;
         ref_src_r <= ref_src_nxt;
         ref_sel_r <= ref_sel_nxt;
         pdn_r <= pdn_nxt;
         gain_r <= gain_nxt;
         byp_r <= byp_nxt;
      end
   end

   // ==========================================================
   // effective format and reference, strap unless overridden
   always_comb begin
      fmt_eff_nxt = fmt_src_r ? fmt_sel_r : format_ref_strap_pin_i;
      ref_eff_nxt = ref_src_r ? ref_sel_r : format_ref_strap_pin_i;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fmt_eff_r <= 1'b0;
         ref_eff_r <= 1'b0;
      end else begin
         fmt_eff_r <= fmt_eff_nxt;
         ref_eff_r <= ref_eff_nxt;
      end
   end

   // outputs straight from flops
   assign readback_data_out_o = rd_out_r;
   assign readback_en_o = rb_r;
   assign distortion_tuning_bits_o = dist_r;
   assign offset_binary_o = fmt_eff_r;
   assign ext_reference_o = ref_eff_r;
   assign power_down_bit_o = pdn_r;
   assign fine_gain_o = gain_r;
   assign gain_bypass_o = byp_r;

   // ==========================================================
   // assertions
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   soft_init_defaults_a: assert property (soft_init |=>
      (!rb_r && dist_r == 8'h00 && !fmt_src_r && !fmt_sel_r && !ref_src_r &&
       !ref_sel_r && !pdn_r && gain_r == 4'h0 && !byp_r))
      else $error("software init left a register off its default");
   readback_set_a: assert property (wr_stb && wr_addr == 8'h00 && !soft_init |=>
      rb_r == $past(wr_data[0]))
      else $error("readback bit did not follow the write");
   format_strap_a: assert property (!fmt_src_r |=>
      offset_binary_o == $past(format_ref_strap_pin_i))
      else $error("format does not follow strap pin");
   format_reg_a: assert property (fmt_src_r |=> offset_binary_o == $past(fmt_sel_r))
      else $error("format does not follow register bit");
   ref_strap_a: assert property (!ref_src_r |=>
      ext_reference_o == $past(format_ref_strap_pin_i))
      else $error("reference does not follow strap pin");
   ref_reg_a: assert property (ref_src_r |=> ext_reference_o == $past(ref_sel_r))
      else $error("reference does not follow register bit");
   gain_write_a: assert property (wr_stb && !rb_r && wr_addr == 8'h45 |=>
      fine_gain_o == $past(wr_data[7:4]) && gain_bypass_o == $past(wr_data[3]))
      else $error("gain write not applied");
   word_len_a: assert property (sclk_fall && !serial_select_n_i |=>
      cnt_r == $past(cnt_r) + 4'h1)
      else $error("bit counter missed a falling edge");
   readback_block_a: assert property (rb_r && wr_stb && wr_addr != 8'h00 |=>
      $stable(gain_r) && $stable(dist_r) && $stable(pdn_r) && $stable(fmt_src_r))
      else $error("write passed while readback enabled");
   readback_out_a: assert property (!rb_r |-> ##1 !readback_data_out_o [*2])
      else $error("readback pin driven outside readback");
   init_clear_a: assert property (sclk_fall && !serial_select_n_i && cnt_r == 4'h7 &&
      shift_r[6:0] == 7'h00 && !serial_data_in_i |=> !rd_shift_r[acrb_pkg::SOFT_INIT_BIT])
      else $error("init bit read back as set");
   reserved_zero_a: assert property ((dist_r & 8'h8E) == 8'h00)
      else $error("reserved distortion bits stored");

   soft_init_c: cover property (soft_init);
   readback_word_c: cover property (rb_r && wr_stb && wr_addr == 8'h45);
   override_c: cover property (fmt_src_r && ref_src_r && byp_r);

endmodule

`default_nettype wire

/* File: sim/acrb_ctl_model.sv */
// controller model for the configuration register bank: drives the three-wire port
// assumes the bank samples the serial pins with clk_i; phases of 4 clk each
`timescale 1ns/1ps
`default_nettype none

module acrb_ctl_model (
   // clock
   input wire logic clk_i,
   // serial port
   output logic serial_clk_o,
   output logic serial_select_n_o,
   output logic serial_data_in_o,
   input wire logic readback_data_out_i
);
   // ==========================================================
   // idle: clock parked high, select high
   initial begin
      serial_clk_o = 1'b1;
      serial_select_n_o = 1'b1;
      serial_data_in_o = 1'b0;
   end

   // waits n cycles and lands just after the edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   // one bit: data set while clock high, taken at the fall
   task automatic bit_out(input logic b, output logic seen);
      serial_data_in_o = b;
      tick(4);
      seen = readback_data_out_i; // latched at the fall
      serial_clk_o = 1'b0;
      tick(4);
      serial_clk_o = 1'b1;
   endtask

   // select low well ahead of the first fall
   task automatic open_frame();
      tick(1);
      serial_select_n_o = 1'b0;
      tick(2);
   endtask

   // select high; the released data line flips so stale bits never look valid
   task automatic close_frame();
      tick(4);
      serial_select_n_o = 1'b1;
      serial_data_in_o = ~serial_data_in_o;
      tick(2);
   endtask

   // address then data, msb first; reserved bits are sent as the caller gives them
   task automatic word(input logic [15:0] w, output logic [7:0] rd);
      logic s;
      for (int i = 15; i >= 0; i--) begin
         bit_out(w[i], s);
         if (i < 8) rd[i] = s;
      end
   endtask

   // loose bits for partial and excess words
   task automatic nibble(input logic [3:0] n);
      logic s;
      for (int i = 3; i >= 0; i--) bit_out(n[i], s);
   endtask
endmodule
`default_nettype wire

/* File: sim/acrb_bank_bench.sv */
// self-checking bench of the configuration register bank
// assumes acrb_ctl_model as the serial controller, 250 MHz clock
`timescale 1ns/1ps
`default_nettype none

module acrb_bank_bench;
   logic clk_i = 1'b0;
   logic rst_i;
   logic strap;
   wire sclk;
   wire sel_n;
   wire sdi;
   logic rbo, rb_en, ofs, ext, pd, byp;
   logic [7:0] tune;
   logic [7:0] d;
   logic [3:0] gain;
   int n_errors = 0;
   int comparisons = 0;

   // ==========================================================
   // clock, design and controller
   always #2 clk_i = ~clk_i;

   acrb_bank dut (.clk_i(clk_i), .rst_i(rst_i), .serial_clk_i(sclk),
      .serial_select_n_i(sel_n), .serial_data_in_i(sdi), .readback_data_out_o(rbo),
      .format_ref_strap_pin_i(strap), .readback_en_o(rb_en),
      .distortion_tuning_bits_o(tune), .offset_binary_o(ofs), .ext_reference_o(ext),
      .power_down_bit_o(pd), .fine_gain_o(gain), .gain_bypass_o(byp));

   acrb_ctl_model host (.clk_i(clk_i), .serial_clk_o(sclk), .serial_select_n_o(sel_n),
      .serial_data_in_o(sdi), .readback_data_out_i(rbo));

   // ==========================================================
   // comparison, verdict and bus tasks
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      logic [7:0] rd;
      host.open_frame();
      host.word({a, v}, rd);
      host.close_frame();
   endtask

   task automatic rdreg(input logic [7:0] a, output logic [7:0] v);
      host.open_frame();
      host.word({a, 8'h00}, v);
      host.close_frame();
   endtask

   task automatic set_strap(input logic v);
      strap = v;
      host.tick(2);
   endtask

   // ==========================================================
   // scenarios
   task automatic test_reset();
      check({rb_en, pd, byp}, 8'h00);
      check(tune, 8'h00);
      check(gain, 4'h0);
      check({ofs, ext}, 8'h03);
      set_strap(1'b0);
      check({ofs, ext}, 8'h00);
   endtask

   task automatic test_tuning();
      wr(acrb_pkg::DISTORTION_TUNING_CTL, 8'h71);
      check(tune, 8'h71);
      wr(acrb_pkg::DISTORTION_TUNING_CTL, 8'hFF);
      check(tune, 8'h71);
   endtask

   task automatic test_format();
      set_strap(1'b1);
      wr(acrb_pkg::OUTPUT_FORMAT_CTL, 8'h80);
      check(ofs, 8'h00);
      wr(acrb_pkg::OUTPUT_FORMAT_CTL, 8'hC0);
      check(ofs, 8'h01);
      wr(acrb_pkg::OUTPUT_FORMAT_CTL, 8'h40);
      set_strap(1'b0);
      check(ofs, 8'h00);
      wr(acrb_pkg::OUTPUT_FORMAT_CTL, 8'h00);
   endtask

   task automatic test_reference();
      set_strap(1'b1);
      wr(acrb_pkg::REFERENCE_AND_POWER_CTL, 8'h08);
      check(ext, 8'h00);
      wr(acrb_pkg::REFERENCE_AND_POWER_CTL, 8'h0C);
      check(ext, 8'h01);
      wr(acrb_pkg::REFERENCE_AND_POWER_CTL, 8'h44);
      set_strap(1'b0);
      check({pd, ext}, 8'h02);
      wr(acrb_pkg::REFERENCE_AND_POWER_CTL, 8'h00);
   endtask

   task automatic test_gain();
      wr(acrb_pkg::GAIN_CTL, 8'h83);
      check({gain, byp}, 8'h10);
      wr(acrb_pkg::GAIN_CTL, 8'hC8);
      check({gain, byp}, 8'h19);
   endtask

   // excess bits dropped, partial word dropped, words back to back
   task automatic test_framing();
      host.open_frame();
      host.word({acrb_pkg::GAIN_CTL, 8'h50}, d);
      host.nibble(4'hF);
      host.close_frame();
      check({gain, byp}, 8'h0A);
      host.open_frame();
      host.nibble(4'h4);
      host.nibble(4'h5);
      host.nibble(4'hF);
      host.close_frame();
      check({gain, byp}, 8'h0A);
      host.open_frame();
      host.word({acrb_pkg::DISTORTION_TUNING_CTL, 8'h01}, d);
      host.word({acrb_pkg::GAIN_CTL, 8'h90}, d);
      host.close_frame();
      check(tune, 8'h01);
      check({gain, byp}, 8'h12);
   endtask

   task automatic test_readback();
      wr(acrb_pkg::INIT_AND_READBACK_CTL, 8'h01);
      check(rb_en, 8'h01);
      rdreg(acrb_pkg::GAIN_CTL, d);
      check(d, 8'h90);
      rdreg(acrb_pkg::DISTORTION_TUNING_CTL, d);
      check(d, 8'h01);
      rdreg(8'h10, d);
      check(d, 8'h00);
      wr(acrb_pkg::GAIN_CTL, 8'h00);
      check({gain, byp}, 8'h12);
      wr(acrb_pkg::INIT_AND_READBACK_CTL, 8'h02);
      check({rb_en, rbo}, 8'h00);
      check({gain, byp}, 8'h12);
   endtask

   task automatic test_init();
      wr(acrb_pkg::REFERENCE_AND_POWER_CTL, 8'h40);
      wr(acrb_pkg::INIT_AND_READBACK_CTL, 8'h02);
      check({pd, gain, byp}, 8'h00);
      check(tune, 8'h00);
      wr(acrb_pkg::INIT_AND_READBACK_CTL, 8'h01);
      rdreg(acrb_pkg::INIT_AND_READBACK_CTL, d);
      check(d, 8'h01);
      wr(acrb_pkg::INIT_AND_READBACK_CTL, 8'h00);
      wr(acrb_pkg::GAIN_CTL, 8'hF0);
      rst_i = 1'b1;
      host.tick(2);
      rst_i = 1'b0;
      host.tick(2);
      check(gain, 4'h0);
   endtask

   // ==========================================================
   // main sequence and watchdog
   initial begin
      rst_i = 1'b1;
      strap = 1'b1;
      host.tick(6);
      rst_i = 1'b0;
      host.tick(2);
      test_reset();
      test_tuning();
      test_format();
      test_reference();
      test_gain();
      test_framing();
      test_readback();
      test_init();
      print_verdict();
   end

   initial begin
      #100000;
      n_errors++;
      print_verdict();
   end
endmodule
`default_nettype wire
